// ===== hw/mtd_pkg.sv
// shared constants and types of the dual track stripe decoder
package mtd_pkg;

	localparam int unsigned MCLK_HZ        = 40_000_000;
	localparam int unsigned MCLK_PER_US    = MCLK_HZ / 1_000_000;

	// data-to-strobe setup and detect-to-first-strobe, both in microseconds
	localparam int unsigned SETUP_US       = 2;
	localparam int unsigned DETECT_US      = 2;
	localparam int unsigned SETUP_CYC      = SETUP_US * MCLK_PER_US;
	localparam int unsigned DETECT_CYC     = DETECT_US * MCLK_PER_US;

	// bit duration = 1e6 / (speed * density) microseconds
	localparam int unsigned SPEED_MIN_IPS  = 3;
	localparam int unsigned SPEED_MAX_IPS  = 100;
	localparam int unsigned DENS_LO_BPI    = 75;
	localparam int unsigned DENS_HI_BPI    = 210;
	localparam int unsigned BIT_MAX_CYC    = MCLK_HZ / (SPEED_MIN_IPS * DENS_LO_BPI);
	localparam int unsigned BIT_MIN_CYC    = MCLK_HZ / (SPEED_MAX_IPS * DENS_HI_BPI);
	localparam int unsigned WIDTH_W        = $clog2(BIT_MAX_CYC + 1);

	// silence longer than two of the slowest cells puts a channel to sleep
	localparam int unsigned IDLE_TIMEOUT_CYC = 2 * BIT_MAX_CYC;

	localparam int unsigned WAKE_CELLS     = 6;
	localparam int unsigned CELL_CNT_W     = 3;

	localparam int unsigned GAIN_DEFAULT   = 128;
	localparam logic [7:0]  THRESH_RESET   = 8'h10;

	typedef enum logic [0:0] {
		MTD_SLEEP,
		MTD_AWAKE
	} mtd_wake_e;

	typedef enum logic [1:0] {
		MTD_OUT_IDLE,
		MTD_OUT_SETUP,
		MTD_OUT_LOW,
		MTD_OUT_HIGH
	} mtd_out_e;

endpackage

// ===== hw/mtd_bit_if.sv
// carrier of decoded bits and their widths between buffer and serial stage
`timescale 1ns/10ps
`default_nettype none
interface mtd_bit_if #(
	parameter int unsigned W = 18
);
	logic         valid;
	logic         ready;
	logic         one;
	logic [W-1:0] width;

	modport src (output valid, output one, output width, input ready);
	modport snk (input valid, input one, input width, output ready);
endinterface
`default_nettype wire

// ===== hw/mtd_bit_fifo.sv
// per-track bit buffer between decoder and serial output stage
`timescale 1ns/10ps
`default_nettype none
module mtd_bit_fifo #(
	parameter int unsigned DEPTH = 16,
	parameter int unsigned W     = 18
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         wr_valid,
	output logic              wr_ready,
	input  wire logic         wr_one,
	input  wire logic [W-1:0] wr_width,
	mtd_bit_if.src            rd
);
	localparam int unsigned AW = $clog2(DEPTH);

	logic [W:0]  mem [DEPTH];
	logic [AW:0] wr_ptr_r;
	logic [AW:0] rd_ptr_r;
	logic        do_wr;
	logic        do_rd;

	assign wr_ready = (wr_ptr_r - rd_ptr_r) != (AW+1)'(DEPTH);
	assign rd.valid = wr_ptr_r != rd_ptr_r;
	assign do_wr    = wr_valid && wr_ready;
	assign do_rd    = rd.valid && rd.ready;
	assign rd.one   = mem[rd_ptr_r[AW-1:0]][W];
	assign rd.width = mem[rd_ptr_r[AW-1:0]][W-1:0];

	always_ff @(posedge clk) begin
		if (do_wr) begin
			mem[wr_ptr_r[AW-1:0]] <= {wr_one, wr_width};
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
		end else begin
			if (do_wr) begin
				wr_ptr_r <= wr_ptr_r + 1'b1;
			end
			if (do_rd) begin
				rd_ptr_r <= rd_ptr_r + 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ===== hw/mtd_serial_out.sv
// serial data and strobe generator for one track
`timescale 1ns/10ps
`default_nettype none
module mtd_serial_out import mtd_pkg::*; #(
	parameter int unsigned W = WIDTH_W
) (
	input  wire logic mclk,
	input  wire logic rst_n,
	input  wire logic enable,
	mtd_bit_if.snk    bits,
	output logic      strobe,
	output logic      serial_bit,
	output logic      idle
);
	mtd_out_e     state_r;
	logic [W-1:0] cnt_r;
	logic [W-1:0] half_r;
	logic [W-1:0] next_half_r;
	logic         pend_r;
	logic         take;

	// halves shorter than the setup window would break the data-to-strobe gap
	function automatic logic [W-1:0] half_of(input logic [W-1:0] w);
		logic [W-1:0] h;
		h = w >> 1;
		half_of = (h > W'(SETUP_CYC)) ? h : W'(SETUP_CYC + 1);
	endfunction

	assign take = bits.valid && !pend_r &&
		((state_r == MTD_OUT_IDLE && enable) ||
		 (state_r == MTD_OUT_HIGH && cnt_r == half_r - W'(SETUP_CYC + 1)));
	assign bits.ready = take;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_r     <= MTD_OUT_IDLE;
			cnt_r       <= '0;
			half_r      <= '0;
			next_half_r <= '0;
			pend_r      <= 1'b0;
			strobe      <= 1'b1;
			serial_bit  <= 1'b1;
			idle        <= 1'b1;
		end else begin
			if (take) begin
				serial_bit  <= !bits.one;
				next_half_r <= half_of(bits.width);
			end
			unique case (state_r)
				MTD_OUT_IDLE: begin
					strobe <= 1'b1;
					idle   <= !take;
					if (take) begin
						cnt_r   <= '0;
						state_r <= MTD_OUT_SETUP;
					end
				end
				MTD_OUT_SETUP: begin
					cnt_r <= cnt_r + 1'b1;
					if (cnt_r == W'(DETECT_CYC - 1)) begin
						strobe  <= 1'b0;
						half_r  <= next_half_r;
						cnt_r   <= '0;
						state_r <= MTD_OUT_LOW;
					end
				end
				MTD_OUT_LOW: begin
					cnt_r <= cnt_r + 1'b1;
					if (cnt_r == half_r - 1'b1) begin
						strobe  <= 1'b1;
						cnt_r   <= '0;
						state_r <= MTD_OUT_HIGH;
					end
				end
				MTD_OUT_HIGH: begin
					cnt_r <= cnt_r + 1'b1;
					if (take) begin
						pend_r <= 1'b1;
					end
					// trailing high of one half after the last rise
					if (cnt_r == half_r - 1'b1) begin
						cnt_r <= '0;
						if (pend_r) begin
							pend_r  <= 1'b0;
							strobe  <= 1'b0;
							half_r  <= next_half_r;
							state_r <= MTD_OUT_LOW;
						end else begin
							idle    <= 1'b1;
							state_r <= MTD_OUT_IDLE;
						end
					end
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// ===== hw/mtd_decoder_top.sv
// two-track stripe decoder: peak capture, F2F decode, gain control, output stage
//
// Behaviour
// - two identical channels, each with peak input, decoder, buffer, data and strobe
// - wake a channel on a detected peak; sleep after prolonged silence
// - gain word starts at 128; each step halves or doubles it
// - track peaks above noise threshold; compare each with the previous
// - peaks bound bits; width against running average gives F2F decode
// - every decoded bit goes into the channel's buffer for the output stage; bits arriving while it is full are lost
// - gain follows current versus previous peak amplitude; peak threshold is half the current peak, floored
// - strobe period equals bit width, low for half of it
// - data high means bit zero, low means bit one
// - strobe rests high, pulses low once per bit
// - shared media-detect rests high, low while media is present
// - media-detect is open drain; pull-up off while driven low
// - data settles 2 us before its strobe falling edge
// - media-detect goes low only after 6 bit cells since wake-up
// - first strobe fall comes 2 us after media-detect falls
// - media-detect releases once both channels sleep, both buffers are empty and both outputs are idle
// - bit-width measurement covers 75 and 210 bits per inch
// - width counters span swipes from 3 to 100 inches per second
`timescale 1ns/10ps
`default_nettype none
module mtd_decoder_top import mtd_pkg::*; #(
	parameter int unsigned IDLE_TIMEOUT = IDLE_TIMEOUT_CYC,
	parameter int unsigned AMP_W        = 8,
	parameter int unsigned GAIN_W       = 12,
	parameter int unsigned FIFO_DEPTH   = 16
) (
	input  wire logic              mclk,
	input  wire logic              rst_n,
	input  wire logic              afe_clk,
	input  wire logic              sig_detect_a,
	input  wire logic              sig_detect_b,
	input  wire logic              afe_peak_a,
	input  wire logic              afe_peak_b,
	input  wire logic [AMP_W-1:0]  afe_amp_a,
	input  wire logic [AMP_W-1:0]  afe_amp_b,
	output logic      [GAIN_W-1:0] track_a_gain,
	output logic      [GAIN_W-1:0] track_b_gain,
	output logic      [AMP_W-1:0]  track_a_thresh,
	output logic      [AMP_W-1:0]  track_b_thresh,
	output logic                   track_a_strobe,
	output logic                   track_a_serial_bit,
	output logic                   track_b_strobe,
	output logic                   track_b_serial_bit,
	input  wire logic              media_present_n_i,
	output logic                   media_present_n_o,
	output logic                   media_present_n_oe,
	output logic                   media_pullup_en
);
	localparam int unsigned TO_W = $clog2(IDLE_TIMEOUT + 1);
	localparam int unsigned W    = WIDTH_W;

	logic             det_in   [2];
	logic             peak_in  [2];
	logic [AMP_W-1:0] amp_in   [2];
	logic [GAIN_W-1:0] gain_r  [2];
	logic [AMP_W-1:0] thr_r    [2];
	logic             strobe_w [2];
	logic             sbit_w   [2];
	logic             out_idle [2];
	logic             awake    [2];
	logic             md_want  [2];
	logic             fifo_mt  [2];
	logic             md_r;

	assign det_in[0]  = sig_detect_a;
	assign det_in[1]  = sig_detect_b;
	assign peak_in[0] = afe_peak_a;
	assign peak_in[1] = afe_peak_b;
	assign amp_in[0]  = afe_amp_a;
	assign amp_in[1]  = afe_amp_b;

	assign track_a_gain       = gain_r[0];
	assign track_b_gain       = gain_r[1];
	assign track_a_thresh     = thr_r[0];
	assign track_b_thresh     = thr_r[1];
	assign track_a_strobe     = strobe_w[0];
	assign track_a_serial_bit = sbit_w[0];
	assign track_b_strobe     = strobe_w[1];
	assign track_b_serial_bit = sbit_w[1];

	// short interval: anything under three quarters of the running average
	function automatic logic is_half(input logic [W-1:0] w, input logic [W-1:0] avg);
		logic [W+1:0] w4;
		logic [W+1:0] a3;
		w4 = {w, 2'b00};
		a3 = {2'b00, avg} + {1'b0, avg, 1'b0};
		is_half = w4 < a3;
	endfunction

	// running average weighting the history three to one
	function automatic logic [W-1:0] avg_mix(input logic [W-1:0] avg, input logic [W-1:0] w);
		logic [W+1:0] s;
		s = {2'b00, avg} + {1'b0, avg, 1'b0} + {2'b00, w};
		avg_mix = s[W+1:2];
	endfunction

	for (genvar ch = 0; ch < 2; ch++) begin : g_chan
		// ---- link side: capture amplitude, hand over by toggle handshake
		logic             req_r;
		logic [AMP_W-1:0] hold_r;
		logic             ack_s1;
		logic             ack_s2;
		// ---- core side
		logic             req_s1, req_s2, req_s3, req_lvl;
		logic             det_s1, det_s2, det_s3, det_lvl;
		logic             ack_r;
		logic             pk_evt;
		logic             pk_ok;
		mtd_wake_e        wake_r;
		logic [TO_W-1:0]  quiet_r;
		logic [W-1:0]     cnt_r;
		logic [W-1:0]     avg_r;
		logic [W-1:0]     half_sum_r;
		logic             have_edge_r;
		logic             half_pend_r;
		logic [CELL_CNT_W-1:0] cells_r;
		logic [AMP_W-1:0] prev_amp_r;
		logic             wr_valid_r;
		logic             wr_one_r;
		logic [W-1:0]     wr_width_r;
		logic             wr_ready;
		mtd_bit_if #(.W(W)) bif ();

		// link domain holds the word until the core acknowledges it
		always_ff @(posedge afe_clk or negedge rst_n) begin
			if (!rst_n) begin
				req_r  <= 1'b0;
				hold_r <= '0;
				ack_s1 <= 1'b0;
				ack_s2 <= 1'b0;
			end else begin
				ack_s1 <= ack_r;
				ack_s2 <= ack_s1;
				if (peak_in[ch] && req_r == ack_s2) begin
					hold_r <= amp_in[ch];
					req_r  <= !req_r;
				end
			end
		end

		always_ff @(posedge mclk or negedge rst_n) begin
			if (!rst_n) begin
				req_s1  <= 1'b0;
				req_s2  <= 1'b0;
				req_s3  <= 1'b0;
				req_lvl <= 1'b0;
				det_s1  <= 1'b0;
				det_s2  <= 1'b0;
				det_s3  <= 1'b0;
				det_lvl <= 1'b0;
				ack_r   <= 1'b0;
			end else begin
				req_s1 <= req_r;
				req_s2 <= req_s1;
				req_s3 <= req_s2;
				det_s1 <= det_in[ch];
				det_s2 <= det_s1;
				det_s3 <= det_s2;
				if (req_s2 == req_s3) begin
					req_lvl <= req_s3;
				end
				if (det_s2 == det_s3) begin
					det_lvl <= det_s3;
				end
				if (pk_evt) begin
					ack_r <= req_s3;
				end
			end
		end

		assign pk_evt = (req_s2 == req_s3) && (req_s3 != req_lvl);
		assign pk_ok  = pk_evt && (hold_r >= thr_r[ch]);

		// wake and sleep
		always_ff @(posedge mclk or negedge rst_n) begin
			if (!rst_n) begin
				wake_r  <= MTD_SLEEP;
				quiet_r <= '0;
			end else begin
				unique case (wake_r)
					MTD_SLEEP: begin
						quiet_r <= '0;
						if (pk_evt && det_lvl) begin
							wake_r <= MTD_AWAKE;
						end
					end
					MTD_AWAKE: begin
						if (pk_ok || det_lvl) begin
							quiet_r <= '0;
						end else if (quiet_r == TO_W'(IDLE_TIMEOUT - 1)) begin
							wake_r <= MTD_SLEEP;
						end else begin
							quiet_r <= quiet_r + 1'b1;
						end
					end
				endcase
			end
		end

		assign awake[ch] = wake_r == MTD_AWAKE;

		// gain and threshold steering from consecutive peak amplitudes
		always_ff @(posedge mclk or negedge rst_n) begin
			if (!rst_n) begin
				gain_r[ch]  <= GAIN_W'(GAIN_DEFAULT);
				thr_r[ch]   <= AMP_W'(THRESH_RESET);
				prev_amp_r  <= '0;
			end else if (pk_evt && awake[ch]) begin
				prev_amp_r <= hold_r;
				if ({1'b0, hold_r} > {prev_amp_r, 1'b0} && gain_r[ch] > GAIN_W'(1)) begin
					gain_r[ch] <= gain_r[ch] >> 1;
				end else if ({hold_r, 1'b0} < {1'b0, prev_amp_r} &&
						!gain_r[ch][GAIN_W-1]) begin
					gain_r[ch] <= gain_r[ch] << 1;
				end
				if (pk_ok) begin
					thr_r[ch] <= ((hold_r >> 1) > AMP_W'(THRESH_RESET)) ?
						(hold_r >> 1) : AMP_W'(THRESH_RESET);
				end
			end
		end

		// bit-width measurement and F2F decode
		always_ff @(posedge mclk or negedge rst_n) begin
			if (!rst_n) begin
				cnt_r       <= '0;
				avg_r       <= '0;
				half_sum_r  <= '0;
				have_edge_r <= 1'b0;
				half_pend_r <= 1'b0;
				cells_r     <= '0;
				wr_valid_r  <= 1'b0;
				wr_one_r    <= 1'b0;
				wr_width_r  <= '0;
			end else begin
				wr_valid_r <= 1'b0;
				// saturates at the slowest cell so slow swipes stay measurable
				if (cnt_r != W'(BIT_MAX_CYC)) begin
					cnt_r <= cnt_r + 1'b1;
				end
				if (!awake[ch]) begin
					avg_r       <= '0;
					have_edge_r <= 1'b0;
					half_pend_r <= 1'b0;
					cells_r     <= '0;
				end else if (pk_ok) begin
					cnt_r <= '0;
					if (!have_edge_r) begin
						have_edge_r <= 1'b1;
					end else if (avg_r == '0) begin
						avg_r      <= cnt_r;
						wr_valid_r <= 1'b1;
						wr_one_r   <= 1'b0;
						wr_width_r <= cnt_r;
					end else if (is_half(cnt_r, avg_r)) begin
						half_pend_r <= !half_pend_r;
						half_sum_r  <= cnt_r;
						if (half_pend_r) begin
							avg_r      <= avg_mix(avg_r, half_sum_r + cnt_r);
							wr_valid_r <= 1'b1;
							wr_one_r   <= 1'b1;
							wr_width_r <= half_sum_r + cnt_r;
						end
					end else begin
						// a lone half before a full cell is treated as noise
						half_pend_r <= 1'b0;
						avg_r       <= avg_mix(avg_r, cnt_r);
						wr_valid_r  <= 1'b1;
						wr_one_r    <= 1'b0;
						wr_width_r  <= cnt_r;
					end
				end
				if (wr_valid_r && cells_r != CELL_CNT_W'(WAKE_CELLS)) begin
					cells_r <= cells_r + 1'b1;
				end
			end
		end

		assign md_want[ch] = awake[ch] && cells_r == CELL_CNT_W'(WAKE_CELLS);
		assign fifo_mt[ch] = !bif.valid;

		// bits arriving into a full buffer are lost; the card cannot be stalled
		mtd_bit_fifo #(
			.DEPTH (FIFO_DEPTH),
			.W     (W)
		) u_fifo (
			.clk      (mclk),
			.rst_n    (rst_n),
			.wr_valid (wr_valid_r),
			.wr_ready (wr_ready),
			.wr_one   (wr_one_r),
			.wr_width (wr_width_r),
			.rd       (bif)
		);

		mtd_serial_out #(
			.W (W)
		) u_out (
			.mclk       (mclk),
			.rst_n      (rst_n),
			.enable     (md_r),
			.bits       (bif),
			.strobe     (strobe_w[ch]),
			.serial_bit (sbit_w[ch]),
			.idle       (out_idle[ch])
		);
	end

	// shared media detect: low while either track has media or bits to send
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			md_r               <= 1'b0;
			media_present_n_o  <= 1'b0;
			media_present_n_oe <= 1'b0;
			media_pullup_en    <= 1'b1;
		end else begin
			if (md_want[0] || md_want[1]) begin
				md_r <= 1'b1;
			end else if (!awake[0] && !awake[1] && fifo_mt[0] && fifo_mt[1] &&
					out_idle[0] && out_idle[1]) begin
				md_r <= 1'b0;
			end
			media_present_n_o  <= 1'b0;
			media_present_n_oe <= md_r;
			media_pullup_en    <= !md_r;
		end
	end
endmodule
`default_nettype wire

// ===== verification/mtd_decoder_monitor.sv
// pin-level assertions for the stripe decoder top
`timescale 1ns/10ps
`default_nettype none
module mtd_decoder_monitor import mtd_pkg::*; #(
	parameter int unsigned AMP_W  = 8,
	parameter int unsigned GAIN_W = 12
) (
	input wire logic              mclk,
	input wire logic              rst_n,
	input wire logic [GAIN_W-1:0] track_a_gain,
	input wire logic [AMP_W-1:0]  track_a_thresh,
	input wire logic              track_a_strobe,
	input wire logic              track_a_serial_bit,
	input wire logic              track_b_strobe,
	input wire logic              media_present_n_o,
	input wire logic              media_present_n_oe,
	input wire logic              media_pullup_en
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);

	pullup_off_a: assert property (media_pullup_en == !media_present_n_oe)
		else $error("pull-up on while line pulled low");
	drain_only_a: assert property (media_present_n_o == 1'b0)
		else $error("media line driven high");
	strobe_in_md_a: assert property (($fell(track_a_strobe) || $fell(track_b_strobe))
		|-> media_present_n_oe) else $error("strobe while media line released");
	data_setup_a: assert property ($changed(track_a_serial_bit)
		|-> ##80 $fell(track_a_strobe)) else $error("data not 2 us ahead of strobe");
	low_half_a: assert property ($fell(track_a_strobe) |-> !track_a_strobe[*8])
		else $error("strobe low pulse too short");
	first_strobe_a: assert property ($rose(media_present_n_oe)
		|-> ##[79:90] ($fell(track_a_strobe) || $fell(track_b_strobe)))
		else $error("first strobe not 2 us after media detect");
	release_idle_a: assert property ($fell(media_present_n_oe) |-> track_a_strobe
		&& track_b_strobe && $past(track_a_strobe) && $past(track_b_strobe))
		else $error("media released during a strobe");
	gain_step_a: assert property ($changed(track_a_gain)
		|-> ({1'b0, track_a_gain} == {$past(track_a_gain), 1'b0})
		|| ({track_a_gain, 1'b0} == {1'b0, $past(track_a_gain)})) else $error("bad gain step");
	thresh_floor_a: assert property (track_a_thresh >= THRESH_RESET)
		else $error("threshold below noise floor");

	cover property ($rose(media_present_n_oe));
	cover property ($fell(media_present_n_oe));
	cover property ($changed(track_a_gain));
endmodule

bind mtd_decoder_top mtd_decoder_monitor #(.AMP_W(AMP_W), .GAIN_W(GAIN_W)) mon_u (.mclk,
	.rst_n, .track_a_gain, .track_a_thresh, .track_a_strobe, .track_a_serial_bit,
	.track_b_strobe, .media_present_n_o, .media_present_n_oe, .media_pullup_en);
`default_nettype wire

// ===== verification/mtd_host_model.sv
// host side: takes each track's bit at its strobe falling edge
`timescale 1ns/10ps
`default_nettype none
module mtd_host_model (
	input  wire logic strobe_a,
	input  wire logic data_a,
	input  wire logic strobe_b,
	input  wire logic data_b,
	input  wire logic md_oe,
	output logic      md_line
);
	logic qa[$];
	logic qb[$];
	int   stray;

	// pull-up wins whenever no device sinks the shared line
	assign md_line = md_oe ? 1'b0 : 1'b1;
	initial stray = 0;

	// sample only inside the media-detect window; low data is a one
	always @(negedge strobe_a) begin
		if (md_line === 1'b0)
			qa.push_back(!data_a);
		else
			stray++;
	end
	always @(negedge strobe_b) begin
		if (md_line === 1'b0)
			qb.push_back(!data_b);
		else
			stray++;
	end
endmodule
`default_nettype wire

// ===== verification/test_dual_track_f2f_decoder.sv
// self-checking bench for the dual track stripe decoder
`timescale 1ns/10ps
`default_nettype none
module test_dual_track_f2f_decoder;
	import mtd_pkg::*;
	logic        mclk, rst_n, afe_clk, sig_a, sig_b, peak_a, peak_b;
	logic [7:0]  amp_a, amp_b, thr_a, thr_b, amp;
	logic [11:0] gain_a, gain_b, gain_e;
	logic [7:0]  prev_amp;
	logic        stb_a, dat_a, stb_b, dat_b, md_o, md_oe, pu_en, md_line;
	int          n_mismatch, comparisons, seed, cw, n;
	logic        exp_a[$];
	logic        exp_b[$];

	mtd_decoder_top #(.IDLE_TIMEOUT(2000)) dut_u (.mclk(mclk), .rst_n(rst_n),
		.afe_clk(afe_clk), .sig_detect_a(sig_a), .sig_detect_b(sig_b),
		.afe_peak_a(peak_a), .afe_peak_b(peak_b), .afe_amp_a(amp_a), .afe_amp_b(amp_b),
		.track_a_gain(gain_a), .track_b_gain(gain_b), .track_a_thresh(thr_a),
		.track_b_thresh(thr_b), .track_a_strobe(stb_a), .track_a_serial_bit(dat_a),
		.track_b_strobe(stb_b), .track_b_serial_bit(dat_b), .media_present_n_i(md_line),
		.media_present_n_o(md_o), .media_present_n_oe(md_oe), .media_pullup_en(pu_en));

	mtd_host_model host_u (.strobe_a(stb_a), .data_a(dat_a), .strobe_b(stb_b),
		.data_b(dat_b), .md_oe(md_oe), .md_line(md_line));

	initial begin
		mclk = 0;
		forever #12.5 mclk = ~mclk;
	end
	initial begin
		afe_clk = 0;
		#7;
		forever #15 afe_clk = ~afe_clk;
	end

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	function automatic logic [7:0] exp_thresh(input logic [7:0] a);
		return ((a >> 1) > THRESH_RESET) ? (a >> 1) : THRESH_RESET;
	endfunction

	// one step per swipe: amplitude is constant inside a swipe
	function automatic logic [11:0] exp_gain(input logic [11:0] g, input logic [7:0] a,
			input logic [7:0] p);
		if ({1'b0, a} > {p, 1'b0} && g > 12'h001)
			return g >> 1;
		if ({a, 1'b0} < {1'b0, p} && !g[11])
			return g << 1;
		return g;
	endfunction

	task automatic pulse(input logic a, input logic b);
		@(posedge afe_clk);
		#1;
		peak_a = a;
		peak_b = b;
		@(posedge afe_clk);
		#1;
		peak_a = 0;
		peak_b = 0;
	endtask

	// first cell is a zero so the running average is seeded on a full width
	task automatic swipe(input int nbits, input int mode);
		logic ba, bb;
		sig_a = 1;
		sig_b = 1;
		amp_a = amp;
		amp_b = amp;
		repeat (10) @(posedge afe_clk);
		pulse(1, 1);
		// the waking peak only opens the channel; the next one is the reference edge
		repeat (cw / 2 - 2) @(posedge afe_clk);
		pulse(1, 1);
		for (int i = 0; i < nbits; i++) begin
			ba = (i == 0) ? 1'b0 : (mode == 1) ? 1'b1 : 1'($random(seed));
			bb = (i == 0 || mode == 1) ? 1'b0 : 1'($random(seed));
			exp_a.push_back(ba);
			exp_b.push_back(bb);
			repeat (cw / 2 - 2) @(posedge afe_clk);
			pulse(ba, bb);
			repeat (cw / 2 - 2) @(posedge afe_clk);
			pulse(1, 1);
		end
		#1;
		sig_a = 0;
		sig_b = 0;
	endtask

	task automatic compare_run();
		check(16'(host_u.qa.size()), 16'(exp_a.size()));
		check(16'(host_u.qb.size()), 16'(exp_b.size()));
		while (exp_a.size() > 0 && host_u.qa.size() > 0)
			check(16'(host_u.qa.pop_front()), 16'(exp_a.pop_front()));
		while (exp_b.size() > 0 && host_u.qb.size() > 0)
			check(16'(host_u.qb.pop_front()), 16'(exp_b.pop_front()));
		check(16'(thr_a), 16'(exp_thresh(amp)));
		check(16'(thr_b), 16'(exp_thresh(amp)));
		check(16'(gain_a), 16'(gain_e));
		check(16'(gain_b), 16'(gain_e));
		check({13'h0000, stb_a, stb_b, pu_en}, 16'h0007);
		check(16'(host_u.stray), 16'h0000);
		exp_a.delete();
		exp_b.delete();
		host_u.qa.delete();
		host_u.qb.delete();
	endtask

	initial begin
		seed = 32'h8fd1_8979;
		n_mismatch = 0;
		comparisons = 0;
		rst_n = 0;
		sig_a = 0;
		sig_b = 0;
		peak_a = 0;
		peak_b = 0;
		amp_a = 8'h00;
		amp_b = 8'h00;
		gain_e = 12'h080;
		prev_amp = 8'h00;
		repeat (2) @(posedge mclk);
		repeat (2) @(posedge afe_clk);
		@(posedge mclk);
		#1;
		rst_n = 1;
		@(posedge mclk);
		#1;
		check(16'(gain_a), 16'h0080);
		check(16'(gain_b), 16'h0080);
		check(16'(thr_a), 16'(THRESH_RESET));
		check({10'h000, stb_a, dat_a, stb_b, dat_b, md_oe, pu_en}, 16'h003d);
		// first swipe leaves the threshold at its floor; later ones stay above it
		for (int s = 0; s < 3; s++) begin
			cw = 260 + 2 * ($random(seed) & 63);
			amp = (s == 0) ? 8'h20 : 8'h41 + 8'($random(seed) & 63);
			gain_e = exp_gain(gain_e, amp, prev_amp);
			prev_amp = amp;
			swipe(10 + 3 * s, s % 2);
			for (n = 0; n < 40000 && md_line !== 1'b1; n++)
				@(posedge mclk);
			if (n == 40000) begin
				n_mismatch++;
				break;
			end
			#1;
			compare_run();
		end
		tally_and_finish();
	end
endmodule
`default_nettype wire
